// ===== core/dcb_channel.sv
// Purpose: DMA channel plus eight-way expander: grants, cycles, parity, interrupts.
// Assumes: One clock, slots drive and sample synchronously to it.
// Notes: Memory is reached through a simple request port; registers via Avalon-MM.
// Behaviour
// RULE1 - Host grant follows a request within three clock periods.
// RULE2 - Slot grant latency depends on priority and higher-slot activity.
// RULE3 - Controller latches grant to gate its drivers.
// RULE4 - Controller issues store or fetch within three clocks of grant.
// RULE5 - Controller drops request with the clock ending its cycle pulse.
// RULE6 - Address and write data captured at the end of the cycle pulse.
// RULE7 - Controller holds grant in a latch through stretched clocks.
// RULE8 - Sixteen-bit open-collector address bus idles high, valid only when granted.
// RULE9 - Granted controller keeps address steady for the whole access.
// RULE10 - Write data gated like address, bit 00 most significant.
// RULE11 - Write bit 16 is odd parity, optional unless parity flag used.
// RULE12 - Channel checks write parity and returns result to controller.
// RULE13 - Read data valid only while read valid strobe is low.
// RULE14 - Read bit 16 is odd parity, driven on one host family only.
// RULE15 - Controller holds interrupt request until recognised.
// RULE16 - On recognition controller drops request and stores status.
// RULE17 - Expander has separate request and recognise lines for eight slots.
// RULE18 - Recognise asserted low when host accepts DMA interrupt.
// RULE19 - First family recognises only with status bit 8 zero, nothing higher.
// RULE20 - Second family recognises only with status bit 12 one, nothing higher.
// RULE21 - Cycle pulse is low for exactly one clock period.
// RULE22 - Read valid strobe low one clock per memory read.
// RULE23 - Fixed priority, slot zero highest, slot seven lowest.
// RULE24 - Held request yields consecutive granted cycles.
// RULE25 - All handshakes active low, synchronous, one clock per pulse.
//
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
module dcb_channel #(
  parameter int SLOTS = 8,
  parameter int READ_LAT = dcb_pkg::READ_LAT_CYC
)
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // Expanded slot side.
  input wire logic [SLOTS-1:0] slot_request_n_in,
  output logic [SLOTS-1:0] slot_grant_n_out,
  input wire logic write_cycle_pulse_n_in,
  input wire logic read_cycle_pulse_n_in,
  input wire logic [15:0] slot_mem_addr_in,
  input wire logic [16:0] slot_write_word_in,
  output logic [16:0] slot_read_word_out,
  output logic read_valid_n_out,
  output logic write_parity_flag_n_out,
  input wire logic [SLOTS-1:0] slot_irq_n_in,
  output logic [SLOTS-1:0] slot_irq_ack_n_out,
  // Memory port.
  output logic mem_write_out,
  output logic mem_read_out,
  output logic [15:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic [15:0] mem_rdata_in,
  // Avalon-MM register slave.
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Odd parity bit for a 16-bit word: set when the word has even ones.
  function automatic logic odd_par(input logic [15:0] w);
    odd_par = ~(^w);
  endfunction : odd_par

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dcb_pkg::dcb_grant_e st;
    logic [2:0] owner;
    logic [SLOTS-1:0] grant_n;
    logic [READ_LAT-1:0] rd_pipe;
    logic [16:0] rword;
    logic rvalid_n;
    logic perr_n;
    logic mwr;
    logic mrd;
    logic [15:0] maddr;
    logic [15:0] mwdata;
    logic [SLOTS-1:0] ack_n;
    logic [2:0] irq_slot;
    logic [31:0] ctrl;
    logic [15:0] hstat;
    logic [15:0] last_wdata;
    logic [31:0] rdata;
    logic ack;
  } dcb_state_s;

  dcb_state_s cur_ff;
  dcb_state_s nxt_cur;
  logic arb_any;
  logic [2:0] arb_pick;
  logic irq_any;
  logic [2:0] irq_pick;
  logic irq_allowed;
  logic cyc_pulse;

  // Request priority encoder.
  dcb_arbiter #(.SLOTS(SLOTS)) u_req_arb
  (
    .slot_request_n_in(slot_request_n_in),
    .any_out(arb_any),
    .pick_out(arb_pick)
  );

  // Interrupt priority encoder shares the same fixed ordering.
  dcb_arbiter #(.SLOTS(SLOTS)) u_irq_arb
  (
    .slot_request_n_in(slot_irq_n_in),
    .any_out(irq_any),
    .pick_out(irq_pick)
  );

  // ---------------------------------------------------------------
  // Interrupt gating by host status
  // ---------------------------------------------------------------
  // Family bit selects which status test admits the DMA interrupt.
  always_comb
  begin
    if (cur_ff.ctrl[dcb_pkg::CTRL_HIGHER_BIT])
      irq_allowed = 1'b0;
    else if (cur_ff.ctrl[dcb_pkg::CTRL_FAMILY_BIT])
      irq_allowed = cur_ff.hstat[dcb_pkg::HSTAT_ENABLE_BIT]; // RULE20
    else
      irq_allowed = !cur_ff.hstat[dcb_pkg::HSTAT_MASK_BIT]; // RULE19
  end

  assign cyc_pulse = !write_cycle_pulse_n_in || !read_cycle_pulse_n_in;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Grant sequencing, memory cycles, parity, reads and registers.
  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.mwr = 1'b0;
    nxt_cur.mrd = 1'b0;
    nxt_cur.rvalid_n = 1'b1;
    nxt_cur.ack = 1'b0;
    nxt_cur.rd_pipe = {cur_ff.rd_pipe[READ_LAT-2:0], 1'b0};
    // Grant sequencer: one wait cycle models the host memory cycle phase.
    case (cur_ff.st)
      dcb_pkg::DCB_IDLE:
      begin
        nxt_cur.grant_n = '1;
        if (arb_any)
        begin
          nxt_cur.owner = arb_pick; // RULE2
          nxt_cur.st = dcb_pkg::DCB_WAIT;
        end
      end
      dcb_pkg::DCB_WAIT:
      begin
        nxt_cur.st = dcb_pkg::DCB_GRANT;
        nxt_cur.grant_n = ~(SLOTS'(1) << cur_ff.owner); // RULE1
      end
      dcb_pkg::DCB_GRANT:
      begin
        if (cyc_pulse)
        begin
          // Capture at the pulse's trailing clock edge.
          nxt_cur.maddr = slot_mem_addr_in; // RULE6
          nxt_cur.mwdata = slot_write_word_in[16:1];
          if (!write_cycle_pulse_n_in)
          begin
            nxt_cur.mwr = 1'b1;
            nxt_cur.last_wdata = slot_write_word_in[16:1];
            // Low flag means the word plus parity bit has even parity.
            nxt_cur.perr_n = (^slot_write_word_in); // RULE12
          end
          else
          begin
            nxt_cur.mrd = 1'b1;
            nxt_cur.rd_pipe[0] = 1'b1;
          end
          // A held request keeps the grant for back-to-back cycles.
          if (slot_request_n_in[cur_ff.owner]) // RULE24
          begin
            nxt_cur.st = dcb_pkg::DCB_IDLE;
            nxt_cur.grant_n = '1;
          end
        end
        else if (slot_request_n_in[cur_ff.owner])
        begin
          nxt_cur.st = dcb_pkg::DCB_IDLE;
          nxt_cur.grant_n = '1;
        end
      end
      default:
      begin
        nxt_cur.st = dcb_pkg::DCB_IDLE;
        nxt_cur.grant_n = '1;
      end
    endcase
    // Read data returns after a fixed memory latency with one-clock valid strobe.
    if (cur_ff.rd_pipe[READ_LAT-1])
    begin
      nxt_cur.rword = {mem_rdata_in,
        cur_ff.ctrl[dcb_pkg::CTRL_FAMILY_BIT] ? odd_par(mem_rdata_in) : 1'b0}; // RULE14
      nxt_cur.rvalid_n = 1'b0; // RULE22 RULE13
    end
    // Recognise the highest slot interrupt once per request.
    if (cur_ff.ack_n == '1 && irq_any && irq_allowed)
    begin
      nxt_cur.ack_n = ~(SLOTS'(1) << irq_pick); // RULE18 RULE17
      nxt_cur.irq_slot = irq_pick;
    end
    else if (cur_ff.ack_n != '1 && slot_irq_n_in[cur_ff.irq_slot])
      nxt_cur.ack_n = '1;
    // Register slave: one cycle of waitrequest, read data loaded on the first edge.
    if ((avs_read || avs_write) && !cur_ff.ack)
    begin
      nxt_cur.ack = 1'b1;
      case (avs_address)
        dcb_pkg::REG_CTRL:
          nxt_cur.rdata = cur_ff.ctrl;
        dcb_pkg::REG_STATUS:
          nxt_cur.rdata = {16'h0, cur_ff.hstat};
        dcb_pkg::REG_STAT_WORD:
          nxt_cur.rdata = {15'h0, ~cur_ff.perr_n, cur_ff.last_wdata};
        dcb_pkg::REG_IRQ:
          nxt_cur.rdata = {17'h0, cur_ff.irq_slot, cur_ff.ack_n, 2'h0, cur_ff.st};
        default:
          nxt_cur.rdata = dcb_pkg::UNMAPPED_READ;
      endcase
    end
    // A write lands only at the edge where waitrequest is seen low.
    if (avs_write && cur_ff.ack)
    begin
      case (avs_address)
        dcb_pkg::REG_CTRL:
          nxt_cur.ctrl = {30'h0, avs_writedata[1:0]};
        dcb_pkg::REG_STATUS:
          nxt_cur.hstat = avs_writedata[15:0];
        default:
          nxt_cur.ctrl = cur_ff.ctrl;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // All state resets to idle with every active-low line released.
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cur_ff <= '0;
      cur_ff.st <= dcb_pkg::DCB_IDLE;
      cur_ff.grant_n <= '1;
      cur_ff.ack_n <= '1;
      cur_ff.rvalid_n <= 1'b1;
      cur_ff.perr_n <= 1'b1;
      cur_ff.ctrl <= dcb_pkg::CTRL_RESET;
      cur_ff.hstat <= dcb_pkg::HSTAT_RESET;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign slot_grant_n_out = cur_ff.grant_n; // RULE25
  assign slot_irq_ack_n_out = cur_ff.ack_n;
  assign slot_read_word_out = cur_ff.rword;
  assign read_valid_n_out = cur_ff.rvalid_n;
  assign write_parity_flag_n_out = cur_ff.perr_n;
  assign mem_write_out = cur_ff.mwr;
  assign mem_read_out = cur_ff.mrd;
  assign mem_addr_out = cur_ff.maddr; // RULE8
  assign mem_wdata_out = cur_ff.mwdata; // RULE10
  assign avs_readdata = cur_ff.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !cur_ff.ack;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_grant_latency: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_IDLE && arb_any) |-> ##[1:3] (slot_grant_n_out != '1)) // RULE1
    else $error("Grant not given within three clocks.");
  a_grant_onehot: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $onehot0(~slot_grant_n_out)) // RULE2
    else $error("More than one slot granted.");
  a_priority_pick: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_IDLE && !slot_request_n_in[0]) |=> (cur_ff.owner == 3'h0)) // RULE23
    else $error("Slot zero lost arbitration.");
  a_read_strobe: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    mem_read_out |-> ##READ_LAT !read_valid_n_out) // RULE22
    else $error("Read valid strobe missing after read.");
  a_read_one: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    !read_valid_n_out |=> read_valid_n_out || $past(cur_ff.rd_pipe[READ_LAT-1])) // RULE13
    else $error("Read valid strobe too long.");
  a_read_par_zero: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($fell(read_valid_n_out) && !cur_ff.ctrl[dcb_pkg::CTRL_FAMILY_BIT])
      |-> (slot_read_word_out[0] == 1'b0)) // RULE14
    else $error("Read parity bit driven on the wrong family.");
  a_write_capture: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_GRANT && !write_cycle_pulse_n_in) |=> (mem_write_out
      && mem_wdata_out == $past(slot_write_word_in[16:1]) && mem_addr_out == $past(slot_mem_addr_in))) // RULE6
    else $error("Store word or address not captured.");
  a_fetch_capture: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_GRANT && !read_cycle_pulse_n_in && write_cycle_pulse_n_in)
      |=> (mem_read_out && mem_addr_out == $past(slot_mem_addr_in))) // RULE6
    else $error("Fetch address not captured.");
  a_parity_flag: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_GRANT && !write_cycle_pulse_n_in)
      |=> (write_parity_flag_n_out == $past(^slot_write_word_in))) // RULE12
    else $error("Write parity result wrong.");
  a_read_parity: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    ($fell(read_valid_n_out) && cur_ff.ctrl[dcb_pkg::CTRL_FAMILY_BIT])
      |-> (^slot_read_word_out == 1'b1)) // RULE14
    else $error("Read word parity is not odd.");
  a_irq_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $fell(|(~slot_irq_ack_n_out) == 1'b0) |-> $past(irq_allowed)) // RULE19
    else $error("Interrupt recognised while gated.");
  a_irq_family: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (slot_irq_ack_n_out == '1 && irq_any && cur_ff.ctrl[0] && !cur_ff.ctrl[1]
      && cur_ff.hstat[12]) |=> (slot_irq_ack_n_out != '1)) // RULE20 RULE18
    else $error("Allowed interrupt not recognised.");
  a_burst_hold: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_GRANT && cyc_pulse && !slot_request_n_in[cur_ff.owner])
      |=> (slot_grant_n_out == $past(slot_grant_n_out))) // RULE24
    else $error("Grant dropped under held request.");
  // Released requests must free the bus and the recognise lines within one clock.
  a_grant_drop: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cur_ff.st == dcb_pkg::DCB_GRANT && !cyc_pulse && slot_request_n_in[cur_ff.owner])
      |=> (slot_grant_n_out == '1)) // RULE25
    else $error("Grant kept after request release.");
  a_ack_release: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (slot_irq_ack_n_out != '1 && slot_irq_n_in[cur_ff.irq_slot]) |=> (slot_irq_ack_n_out == '1)) // RULE18
    else $error("Recognise line held after request drop.");
  a_ack_onehot: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    $onehot0(~slot_irq_ack_n_out)) // RULE17
    else $error("More than one slot recognised.");
endmodule : dcb_channel

// ===== core/dcb_pkg.sv
// Purpose: Shared constants for the DMA channel bus device logic.
// Assumes: One 10 MHz system clock; all handshake lines active low.
// Notes: Offsets, reset values and cycle counts live here.
package dcb_pkg;
  // ---------------------------------------------------------------
  // Bus shape
  // ---------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int ADDR_W = 16;
  localparam int SLOTS = 8;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int GRANT_MAX_NS = 300;
  localparam int GRANT_MAX_CYC = (GRANT_MAX_NS / CLK_NS < 1) ? 1 : GRANT_MAX_NS / CLK_NS;
  localparam int READ_LAT_CYC = 2;
  // ---------------------------------------------------------------
  // Register map, byte addresses on the Avalon slave
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STAT_WORD = 4'h8;
  localparam logic [3:0] REG_IRQ = 4'hC;
  localparam int CTRL_FAMILY_BIT = 0;
  localparam int CTRL_HIGHER_BIT = 1;
  localparam int HSTAT_MASK_BIT = 8;
  localparam int HSTAT_ENABLE_BIT = 12;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [15:0] HSTAT_RESET = 16'h0000;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  // ---------------------------------------------------------------
  // Grant sequencer states, Gray order
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    DCB_IDLE = 2'b00,
    DCB_WAIT = 2'b01,
    DCB_GRANT = 2'b11
  } dcb_grant_e;
endpackage : dcb_pkg

// ===== core/dcb_arbiter.sv
// Purpose: Fixed-priority picker over the eight slot request lines.
// Assumes: Requests are active low; slot 0 wins over slot 7.
// Notes: Purely combinational; the caller registers the result.
module dcb_arbiter #(
  parameter int SLOTS = 8
)
(
  input wire logic [SLOTS-1:0] slot_request_n_in,
  output logic any_out,
  output logic [2:0] pick_out
);
  // Lowest index asserted request takes the grant.
  always_comb
  begin
    any_out = 1'b0;
    pick_out = 3'h0;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (!slot_request_n_in[i])
      begin
        any_out = 1'b1;
        pick_out = 3'(i); // RULE23
      end
    end
  end
endmodule : dcb_arbiter

// ===== verif/dcb_ctl_model.sv
// Purpose: Behavioural device controller sitting on slot 0 of the channel.
// Assumes: Tasks are entered just after a rising clock edge.
// Notes: Released address and data lines read as all ones, like a pulled-up bus.
module dcb_ctl_model
(
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic grant_n_in,
  input wire logic irq_ack_n_in,
  output logic request_n_out,
  output logic write_pulse_n_out,
  output logic read_pulse_n_out,
  output logic [15:0] addr_out,
  output logic [16:0] word_out,
  output logic irq_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic granted_ff;
  logic cur_write;
  logic [15:0] cur_addr;
  logic [16:0] cur_word;
  // ------------------------------------------------------------
  // Grant latch and bus gating
  // ------------------------------------------------------------
  // Latched grant keeps the drivers steady through stretched clocks.
  always @(posedge sys_clk_in or negedge rst_b_in)
    if (!rst_b_in)
      granted_ff <= 1'b0;
    else
      granted_ff <= !grant_n_in;
  // Address drivers are enabled by the latched grant; data drivers also need a write.
  assign addr_out = granted_ff ? cur_addr : 16'hFFFF;
  assign word_out = (granted_ff && cur_write) ? cur_word : 17'h1FFFF;
  initial
  begin
    request_n_out = 1'b1;
    write_pulse_n_out = 1'b1;
    read_pulse_n_out = 1'b1;
    irq_n_out = 1'b1;
    cur_write = 1'b0;
    cur_addr = 16'h0000;
    cur_word = 17'h00000;
  end
  // ------------------------------------------------------------
  // Memory cycles
  // ------------------------------------------------------------
  // Runs n cycles on consecutive addresses; bad flips the parity bit.
  task access(input logic wr, input logic [15:0] a, input logic [15:0] d,
              input logic bad, input int n);
    int k;
    int t;
    logic [15:0] dk;
    @(posedge sys_clk_in);
    request_n_out <= 1'b0;
    for (k = 0; k < n; k++)
    begin
      dk = d + 16'(k);
      cur_write <= wr;
      cur_addr <= a + 16'(k);
      cur_word <= {dk, (~^dk) ^ bad};
      for (t = 0; t < 20; t++)
      begin
        @(posedge sys_clk_in);
        if (grant_n_in === 1'b0)
          break;
      end
      if (t == 20)
        tb_top.chk("grant timeout", 0, 1);
      if (wr)
        write_pulse_n_out <= 1'b0;
      else
        read_pulse_n_out <= 1'b0;
      @(posedge sys_clk_in);
      write_pulse_n_out <= 1'b1;
      read_pulse_n_out <= 1'b1;
      if (k == n - 1)
        request_n_out <= 1'b1;
    end
  endtask : access
  // ------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------
  // Holds the request until recognised, then drops it.
  task irq(input int lim, output logic got);
    got = 1'b0;
    @(posedge sys_clk_in);
    irq_n_out <= 1'b0;
    repeat (lim)
    begin
      @(posedge sys_clk_in);
      if (irq_ack_n_in === 1'b0)
      begin
        got = 1'b1;
        break;
      end
    end
    if (got)
      irq_n_out <= 1'b1;
  endtask : irq
endmodule : dcb_ctl_model

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for the channel with one controller model.
// Assumes: 100 ns clock, bus tasks entered just after a rising edge.
// Notes: A 16-word memory answers the memory port.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:1] oth_req = 7'h7F;
  logic m_req, m_wp, m_rp, m_irq, got;
  logic [15:0] m_addr, mem_addr, mem_wdata, mem_rdata;
  logic [16:0] m_word, rd_word, w;
  logic [7:0] grant_n, ack_n;
  logic rd_valid_n, par_n, mem_wr, mem_rd;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, r;
  logic avs_waitrequest;
  logic [15:0] mem [16];
  int num_errors = 0;
  int samples_checked = 0;
  logic [1:0] c_fam [5] = '{0, 0, 1, 1, 1};
  logic [15:0] c_st [5] = '{16'h0000, 16'h0100, 16'h1000, 16'h0000, 16'h1000};
  logic c_hi [5] = '{0, 0, 0, 0, 1};
  logic c_ok [5] = '{1, 0, 1, 0, 0};
  always #50 sys_clk = ~sys_clk;
  dcb_channel dcb_channel_i (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .slot_request_n_in({oth_req, m_req}), .slot_grant_n_out(grant_n),
    .write_cycle_pulse_n_in(m_wp), .read_cycle_pulse_n_in(m_rp),
    .slot_mem_addr_in(m_addr), .slot_write_word_in(m_word),
    .slot_read_word_out(rd_word), .read_valid_n_out(rd_valid_n),
    .write_parity_flag_n_out(par_n), .slot_irq_n_in({7'h7F, m_irq}),
    .slot_irq_ack_n_out(ack_n), .mem_write_out(mem_wr), .mem_read_out(mem_rd),
    .mem_addr_out(mem_addr), .mem_wdata_out(mem_wdata), .mem_rdata_in(mem_rdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  dcb_ctl_model dcb_ctl_model_i (.sys_clk_in(sys_clk), .rst_b_in(rst_b),
    .grant_n_in(grant_n[0]), .irq_ack_n_in(ack_n[0]), .request_n_out(m_req),
    .write_pulse_n_out(m_wp), .read_pulse_n_out(m_rp), .addr_out(m_addr),
    .word_out(m_word), .irq_n_out(m_irq));
  // Memory behind the memory port.
  always @(posedge sys_clk)
    if (mem_wr)
      mem[mem_addr[3:0]] <= mem_wdata;
  assign mem_rdata = mem[mem_addr[3:0]];
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low.
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 20)
      chk("bus timeout", 0, 1);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // Waits for an exact grant vector and checks how long it took.
  task wait_grant(input logic [7:0] exp, input int max);
    int n;
    for (n = 1; n < 40; n++)
    begin
      @(posedge sys_clk);
      if (grant_n === exp)
        break;
    end
    chk("grant", grant_n, exp);
    chk("grant latency", n <= max, 1);
  endtask : wait_grant
  // Captures the read word on the one-cycle valid strobe.
  task get_read;
    int n;
    for (n = 0; n < 30; n++)
    begin
      @(posedge sys_clk);
      if (rd_valid_n === 1'b0)
        break;
    end
    w = rd_word;
    @(posedge sys_clk);
    chk("valid width", rd_valid_n, 1);
  endtask : get_read
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge sys_clk);
    chk("reset outs", {grant_n, ack_n, rd_valid_n, par_n}, 18'h3FFFF);
    rst_b <= 1'b1;
    bus(0, dcb_pkg::REG_CTRL, 0);
    chk("ctrl reset", r, dcb_pkg::CTRL_RESET);
    bus(0, dcb_pkg::REG_STATUS, 0);
    chk("status reset", r[15:0], dcb_pkg::HSTAT_RESET);
    bus(1, 4'h2, 32'hFFFF_FFFF);
    bus(0, 4'h2, 0);
    chk("unmapped", r, dcb_pkg::UNMAPPED_READ);
    oth_req <= 7'h6D;
    wait_grant(8'hFB, dcb_pkg::GRANT_MAX_CYC);
    oth_req <= 7'h6F;
    wait_grant(8'hDF, 10);
    bus(0, dcb_pkg::REG_IRQ, 0);
    chk("irq reg", r, 32'h0000_0FF3);
    oth_req <= 7'h7F;
    wait_grant(8'hFF, 10);
    dcb_ctl_model_i.access(1, 16'h0005, 16'hA5C3, 0, 1);
    repeat (2) @(posedge sys_clk);
    chk("parity ok", par_n, 1);
    bus(0, dcb_pkg::REG_STAT_WORD, 0);
    chk("stat word", r[16:0], 17'h0A5C3);
    dcb_ctl_model_i.access(1, 16'h0006, 16'h0F0F, 1, 1);
    repeat (2) @(posedge sys_clk);
    chk("parity bad", par_n, 0);
    bus(0, dcb_pkg::REG_STAT_WORD, 0);
    chk("stat word", r[16:0], 17'h10F0F);
    dcb_ctl_model_i.access(1, 16'h0008, 16'h1234, 0, 2);
    repeat (2) @(posedge sys_clk);
    chk("parity ok", par_n, 1);
    for (int f = 0; f < 2; f++)
    begin
      bus(1, dcb_pkg::REG_CTRL, 32'(f));
      bus(0, dcb_pkg::REG_CTRL, 0);
      chk("ctrl", r, 32'(f));
      fork
        dcb_ctl_model_i.access(0, 16'h0009, 16'h0000, 0, 1);
        get_read;
      join
      chk("read 9", w, {16'h1235, f ? ~^16'h1235 : 1'b0});
      fork
        dcb_ctl_model_i.access(0, 16'h0005, 16'h0000, 0, 1);
        get_read;
      join
      chk("read 5", w, {16'hA5C3, f ? ~^16'hA5C3 : 1'b0});
    end
    for (int i = 0; i < 5; i++)
    begin
      bus(1, dcb_pkg::REG_CTRL, {30'h0, c_hi[i], c_fam[i][0]});
      bus(1, dcb_pkg::REG_STATUS, {16'h0, c_st[i]});
      dcb_ctl_model_i.irq(10, got);
      chk("irq gate", got, c_ok[i]);
      if (!got)
      begin
        bus(1, dcb_pkg::REG_CTRL, 0);
        bus(1, dcb_pkg::REG_STATUS, 0);
        dcb_ctl_model_i.irq(10, got);
      end
      chk("ack lines", ack_n, 8'hFE);
      repeat (3) @(posedge sys_clk);
      chk("ack release", ack_n, 8'hFF);
    end
    results();
  end
endmodule : tb_top
